// File: hdl/thumbwheel_params.svh
// Purpose: timing and layout constants for the thumbwheel scanner
// Assumes: core clock of 20 MHz
// Notes:   times are given in their own unit, counts derived from them
`ifndef THUMBWHEEL_PARAMS_SVH
`define THUMBWHEEL_PARAMS_SVH

`define CLK_FREQ_HZ      20000000
`define STEP_TIME_MS     100
`define STEP_CYCLES      ((`CLK_FREQ_HZ / 1000) * `STEP_TIME_MS)
`define DIGIT_COUNT      4
`define DIGIT_BITS       4
`define MAX_BANKS        2
`define RESULT_BITS      16
`define RESULT_RESET     16'h0000
`define STROBE_RESET     4'h0

`endif

// File: hdl/thumbwheel_pkg.sv
// Purpose: types shared by the thumbwheel scanner
// Assumes: constants come from thumbwheel_params.svh
// Notes:   packed structs carry grouped signals
package thumbwheel_pkg;

    // one result word per bank
    typedef struct packed {
        logic [15:0] bank1;
        logic [15:0] bank0;
    } result_pair_t;

    // scanner sequencing states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SCAN
    } scan_state_t;

endpackage

// File: hdl/bcd_thumbwheel_scanner.sv
// Purpose: time-division reader for one or two banks of BCD thumbwheels
// Assumes: sense lines are asynchronous pins; single 20 MHz clock
// Notes:   all outputs are registered; results held while disabled
//
// Overview of operation
// - strobe digits one at a time from first, 100 ms per step
// - each bank holds four decimal digits, value 0 to 9999
// - convert sampled BCD digits to binary before storing
// - bank one goes to base result word, bank two to base plus one
// - one bank samples lines 0..3 under the four strobes
// - two banks also sample lines 4..7 into the second word
// - complete flag low while idle or scanning, except high for the first step after a full cycle
// - on enable drop keep results, drive all strobes low
// - all four strobes driven; unused ones left unconnected outside
// - eight sense lines, upper four used only with two banks
// - two banks occupy two consecutive result words
// - while enabled repeat the four-strobe cycle every 400 ms
`timescale 1ns/100ps
`include "thumbwheel_params.svh"

module bcd_thumbwheel_scanner #(
    parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    // control
    input  wire logic                        scanEnable,
    input  wire logic                        twoBanks,
    // switch side
    input  wire logic [7:0]                  senseLines,
    output logic      [3:0]                  strobeOut,
    // results
    output thumbwheel_pkg::result_pair_t     resultWords,
    output logic                             scanComplete
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]                  senseS1_ff;
    logic [7:0]                  senseS2_ff;
    logic [7:0]                  senseS3_ff;
    logic [7:0]                  senseClean_ff;
    logic [31:0]                 stepCnt_ff;
    logic [1:0]                  digit_ff;
    logic [15:0]                 acc0_ff;
    logic [15:0]                 acc1_ff;
    logic                        twoBanksLat_ff;
    thumbwheel_pkg::scan_state_t state_ff;
    logic                        stepDone;

    // weight a bcd digit by its decade and add it to the running sum
    function automatic logic [15:0] add_digit(
        input logic [15:0] sum,
        input logic [3:0]  bcd,
        input logic [1:0]  pos
    );
        logic [15:0] w;
        w = 16'h0001;
        case (pos)
            2'h0:    w = 16'h0001;
            2'h1:    w = 16'h000A;
            2'h2:    w = 16'h0064;
            2'h3:    w = 16'h03E8;
            default: w = 16'h0001;
        endcase
        // codes above nine are clamped so a bank never passes 9999
        if (bcd > 4'h9) begin
            bcd = 4'h9;
        end
        add_digit = 16'(sum + 16'(w * {12'h000, bcd}));
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser: a change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            senseS1_ff <= 8'h00;
            senseS2_ff <= 8'h00;
            senseS3_ff <= 8'h00;
        end else begin
            senseS1_ff <= senseLines;
            senseS2_ff <= senseS1_ff;
            senseS3_ff <= senseS2_ff;
        end
    end

    // per-bit agreement filter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            senseClean_ff <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (senseS2_ff[i] == senseS3_ff[i]) begin
                    senseClean_ff[i] <= senseS3_ff[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // step timer; the last cycle of a step is the sampling point
    assign stepDone = (stepCnt_ff == STEP_CYCLES - 1);

    // 100 ms step timing
    // held at zero through the idle cycle, else the first step is short
    always_ff @(posedge core_clk) begin
        if (reset || !scanEnable) begin
            stepCnt_ff <= 32'h0000_0000;
        end else if (stepDone || state_ff != thumbwheel_pkg::ST_SCAN) begin
            stepCnt_ff <= 32'h0000_0000;
        end else begin
            stepCnt_ff <= stepCnt_ff + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer state and digit pointer
    // repeat while enabled
    always_ff @(posedge core_clk) begin
        if (reset || !scanEnable) begin
            state_ff <= thumbwheel_pkg::ST_IDLE;
            digit_ff <= 2'h0;
        end else begin
            case (state_ff)
                thumbwheel_pkg::ST_IDLE: begin
                    state_ff <= thumbwheel_pkg::ST_SCAN;
                    digit_ff <= 2'h0;
                end
                thumbwheel_pkg::ST_SCAN: begin
                    if (stepDone) begin
                        digit_ff <= digit_ff + 2'h1; // wraps after fourth
                    end
                end
                default: begin
                    state_ff <= thumbwheel_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // bank count is latched at cycle start so a mid-cycle change is safe
    // only one or two banks
    always_ff @(posedge core_clk) begin
        if (reset) begin
            twoBanksLat_ff <= 1'b0;
        end else if (state_ff == thumbwheel_pkg::ST_IDLE ||
                     (stepDone && digit_ff == 2'h3)) begin
            twoBanksLat_ff <= twoBanks;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strobe outputs: one-hot on the current digit, all low when idle
    // strobes off on disable
    always_ff @(posedge core_clk) begin
        if (reset || !scanEnable) begin
            strobeOut <= `STROBE_RESET;
        end else if (state_ff == thumbwheel_pkg::ST_IDLE) begin
            strobeOut <= 4'h1;
        end else if (stepDone) begin
            strobeOut <= 4'(4'h1 << (digit_ff + 2'h1));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // accumulate digits at end of each step
    // sample at step end
    always_ff @(posedge core_clk) begin
        if (reset || !scanEnable) begin
            acc0_ff <= 16'h0000;
            acc1_ff <= 16'h0000;
        end else if (state_ff == thumbwheel_pkg::ST_SCAN && stepDone) begin
            if (digit_ff == 2'h0) begin
                acc0_ff <= add_digit(16'h0000, senseClean_ff[3:0], 2'h0);
                acc1_ff <= add_digit(16'h0000, senseClean_ff[7:4], 2'h0);
            end else begin
                acc0_ff <= add_digit(acc0_ff, senseClean_ff[3:0], digit_ff);
                acc1_ff <= add_digit(acc1_ff, senseClean_ff[7:4], digit_ff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result words updated once per full cycle, held otherwise
    // binary result
    always_ff @(posedge core_clk) begin
        if (reset) begin
            resultWords.bank0 <= `RESULT_RESET;
            resultWords.bank1 <= `RESULT_RESET;
        end else if (scanEnable && state_ff == thumbwheel_pkg::ST_SCAN &&
                     stepDone && digit_ff == 2'h3) begin
            resultWords.bank0 <= add_digit(acc0_ff, senseClean_ff[3:0],
                                           2'h3);
            if (twoBanksLat_ff) begin
                resultWords.bank1 <= add_digit(acc1_ff,
                                               senseClean_ff[7:4], 2'h3);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // completion flag: rises at the end of each full cycle, and stays
    // up through the first step of the next cycle so a single-shot user can see it
    // complete flag
    always_ff @(posedge core_clk) begin
        if (reset || !scanEnable) begin
            scanComplete <= 1'b0;
        end else if (state_ff == thumbwheel_pkg::ST_SCAN && stepDone) begin
            scanComplete <= (digit_ff == 2'h3);
        end
    end

endmodule // bcd_thumbwheel_scanner

// File: tb/thumbwheel_monitor.sv
// Purpose: port checker for the thumbwheel scanner
// Assumes: one clock domain, synchronous reset
// Notes:   step length follows the STEP_CYCLES parameter
`timescale 1ns/100ps
module thumbwheel_monitor #(
    parameter int unsigned STEP_CYCLES = 8
) (
    // clock and reset
    input wire logic                         core_clk,
    input wire logic                         reset,
    // control and switch side
    input wire logic                         scanEnable,
    input wire logic                         twoBanks,
    input wire logic [7:0]                   senseLines,
    input wire logic [3:0]                   strobeOut,
    // results
    input wire thumbwheel_pkg::result_pair_t resultWords,
    input wire logic                         scanComplete
);
    int unsigned stepCnt_ff;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // cycles since the strobe last moved, so step length is measured
    always_ff @(posedge core_clk) begin
        if (reset || $changed(strobeOut)) begin
            stepCnt_ff <= 0;
        end else begin
            stepCnt_ff <= stepCnt_ff + 1;
        end
    end
    a_strobe_onehot: assert property (
        $past(scanEnable, 2) && $past(scanEnable) && !$past(reset, 2)
        && !$past(reset) |-> $onehot(strobeOut))
        else $error("strobe not one-hot while scanning");
    a_first_digit: assert property (
        $changed(strobeOut) && $past(strobeOut) == 4'h0
        |-> strobeOut == 4'h1) else $error("scan did not start at digit 0");
    a_strobe_rotate: assert property (
        $changed(strobeOut) && $past(strobeOut) != 4'h0 && strobeOut != 4'h0
        |-> strobeOut == 4'(($past(strobeOut) << 1) | ($past(strobeOut) >> 3)))
        else $error("strobe order broken");
    a_step_length: assert property (
        $changed(strobeOut) && $past(strobeOut) != 4'h0 && strobeOut != 4'h0
        |-> stepCnt_ff == STEP_CYCLES - 1) else $error("step length wrong");
    a_strobe_off: assert property (
        !$past(scanEnable) |-> strobeOut == 4'h0)
        else $error("strobe active while disabled");
    a_flag_idle: assert property (
        !$past(scanEnable) |-> !scanComplete) else $error("flag high idle");
    a_flag_rise: assert property (
        $rose(scanComplete) |-> strobeOut == 4'h1 && $past(strobeOut) == 4'h8)
        else $error("flag rose before the fourth digit ended");
    a_flag_step: assert property (
        scanComplete |-> strobeOut == 4'h1) else $error("flag outside step 0");
    a_result_when: assert property (
        $changed(resultWords) && !$past(reset) |-> $rose(scanComplete))
        else $error("result changed outside cycle end");
    a_bank_range: assert property (
        resultWords.bank0 <= 16'h270F && resultWords.bank1 <= 16'h270F)
        else $error("result above four digits");
    a_bank1_gate: assert property (
        $changed(resultWords.bank1) && !$past(reset) |-> twoBanks)
        else $error("second word written with one bank");
endmodule // thumbwheel_monitor
bind bcd_thumbwheel_scanner thumbwheel_monitor #(.STEP_CYCLES(STEP_CYCLES))
    u_mon (.core_clk(core_clk), .reset(reset), .scanEnable(scanEnable),
    .twoBanks(twoBanks), .senseLines(senseLines), .strobeOut(strobeOut),
    .resultWords(resultWords), .scanComplete(scanComplete));

// File: tb/thumbwheel_switches.sv
// Purpose: two banks of four BCD thumbwheel digits
// Assumes: strobes are one-hot and active high
// Notes:   unselected lines show the inverse of the last code
`timescale 1ns/100ps
module thumbwheel_switches (
    // clock
    input wire logic        core_clk,
    // settings, digit k in bits 4k+3..4k
    input wire logic [15:0] setting0,
    input wire logic [15:0] setting1,
    // switch pins
    input wire logic [3:0]  strobeOut,
    output logic     [7:0]  senseLines
);
    logic [7:0] held_ff = 8'h00;
    logic [7:0] selected;
    always_comb begin
        selected = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (strobeOut[k]) begin
                selected = {setting1[4*k +: 4], setting0[4*k +: 4]};
            end
        end
    end
    // last code kept so that idle lines cannot pass for valid data
    always_ff @(posedge core_clk) begin
        if (strobeOut != 4'h0) begin
            held_ff <= selected;
        end
    end
    assign senseLines = (strobeOut != 4'h0) ? selected : ~held_ff;
endmodule // thumbwheel_switches

// File: tb/bcd_thumbwheel_scanner_tb.sv
// Purpose: self-checking bench for the thumbwheel scanner
// Assumes: short step of STEP cycles
// Notes:   table rows first, then repeat and abort cases
`timescale 1ns/100ps
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module bcd_thumbwheel_scanner_tb;
    localparam int unsigned STEP = 8;
    typedef struct packed {
        logic [15:0] sw0;
        logic [15:0] sw1;
        logic        two;
        logic [31:0] want;
    } row_t;
    logic                         core_clk = 1'b0;
    logic                         reset = 1'b1;
    logic                         scanEnable = 1'b0;
    logic                         twoBanks = 1'b0;
    logic [15:0]                  setting0 = 16'h0000;
    logic [15:0]                  setting1 = 16'h0000;
    logic [7:0]                   senseLines;
    logic [3:0]                   strobeOut;
    thumbwheel_pkg::result_pair_t resultWords;
    logic                         scanComplete;
    int                           err_total = 0;
    int                           samples_checked = 0;
    // bank count one or two
    // settings beside the words they give, {bank1, bank0}
    row_t rows [6] = '{'{16'h0000, 16'h0000, 1'b1, 32'h0000_0000},
        '{16'h9999, 16'h5678, 1'b1, 32'h162E_270F},
        '{16'h1234, 16'h0000, 1'b0, 32'h162E_04D2},
        '{16'h0001, 16'h1000, 1'b1, 32'h03E8_0001},
        '{16'h8000, 16'h0009, 1'b1, 32'h0009_1F40},
        '{16'h00F0, 16'h0000, 1'b0, 32'h0009_005A}};
    initial forever #25 core_clk = ~core_clk;
    bcd_thumbwheel_scanner #(.STEP_CYCLES(STEP)) u_dut (.core_clk(core_clk),
        .reset(reset), .scanEnable(scanEnable), .twoBanks(twoBanks),
        .senseLines(senseLines), .strobeOut(strobeOut),
        .resultWords(resultWords), .scanComplete(scanComplete));
    thumbwheel_switches u_sw (.core_clk(core_clk), .setting0(setting0),
        .setting1(setting1), .strobeOut(strobeOut), .senseLines(senseLines));
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bounded wait for the flag level, a timeout ends the run
    task automatic waitFlag(input logic level);
        int n;
        n = 0;
        while (scanComplete !== level && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        if (scanComplete !== level) begin
            err_total++;
            test_done();
        end
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        `CHK({strobeOut, scanComplete, resultWords}, 37'h0)
        reset = 1'b0;
        // single-shot reads, enable held until the flag rises
        foreach (rows[i]) begin
            setting0 = rows[i].sw0;
            setting1 = rows[i].sw1;
            twoBanks = rows[i].two;
            scanEnable = 1'b1;
            waitFlag(1'b1);
            scanEnable = 1'b0;
            `CHK(resultWords, rows[i].want)
            @(negedge core_clk);
            `CHK(strobeOut, 4'h0)
        end
        // held enable: the flag falls, then rises on the next pass
        scanEnable = 1'b1;
        waitFlag(1'b1);
        waitFlag(1'b0);
        `CHK(strobeOut, 4'h2)
        waitFlag(1'b1);
        `CHK(strobeOut, 4'h1)
        // abort in mid-cycle with new settings: words must not move
        setting0 = 16'h4321;
        repeat (3 * STEP) @(negedge core_clk);
        scanEnable = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK({strobeOut, scanComplete, resultWords}, 37'h0_0009_005A)
        // mid-run reset: strobes, flag and words all return to zero
        scanEnable = 1'b1;
        repeat (2 * STEP) @(negedge core_clk);
        reset = 1'b1;
        @(negedge core_clk);
        `CHK({strobeOut, scanComplete, resultWords}, 37'h0)
        reset = 1'b0;
        scanEnable = 1'b0;
        @(negedge core_clk);
        test_done();
    end
endmodule // bcd_thumbwheel_scanner_tb
